// ==== hw/dvs_pkg.sv ====
`default_nettype none
package dvs_pkg;
  // ************************************************************
  // timing
  // ************************************************************
  localparam int unsigned CLK_MHZ        = 125;
  localparam int unsigned OL_TIMEOUT_US  = 10;
  localparam int unsigned ETO_TIMEOUT_US = 20;
  localparam int unsigned OL_CYCLES  = OL_TIMEOUT_US * CLK_MHZ;
  localparam int unsigned ETO_CYCLES = ETO_TIMEOUT_US * CLK_MHZ;
  localparam int unsigned TMR_W      = 16;
  // ************************************************************
  // controller register map (word index on a 4-bit address)
  // ************************************************************
  localparam logic [3:0] ADR_CMD    = 4'h0;
  localparam logic [3:0] ADR_GATE   = 4'h1;
  localparam logic [3:0] ADR_CFG    = 4'h2;
  localparam logic [3:0] ADR_DIAG   = 4'h3;
  localparam logic [3:0] ADR_CLEAR  = 4'h4;
  localparam logic [3:0] ADR_STATUS = 4'h5;
  // command bit positions
  localparam int CMD_BU   = 0;
  localparam int CMD_DO   = 1;
  localparam int CMD_LO   = 2;
  localparam int CMD_OC   = 3;
  localparam int CMD_OL   = 4;
  localparam int CMD_SRC  = 5;
  localparam int CMD_SNK  = 6;
  localparam int CMD_PH   = 7;
  localparam int CMD_W    = 8;
  // gate bits: ha, hb, la, lb
  localparam int GATE_W   = 4;
  // config bits: onstate enable, offstate disable, watchdog select
  localparam int CFG_AOL  = 0;
  localparam int CFG_DOO  = 1;
  localparam int CFG_EWD  = 2;
  localparam int CFG_W    = 3;
  // diag bit positions
  localparam int DG_BUA = 0;
  localparam int DG_BUB = 1;
  localparam int DG_HA  = 2;
  localparam int DG_HB  = 3;
  localparam int DG_LA  = 4;
  localparam int DG_LB  = 5;
  localparam int DG_LOV = 6;
  localparam int DG_OCA = 7;
  localparam int DG_OCB = 8;
  localparam int DG_OL  = 9;
  localparam int DG_ETO = 10;
  localparam int DIAG_W = 11;
  localparam logic [CMD_W-1:0]  CMD_RST  = 8'h00;
  localparam logic [DIAG_W-1:0] DIAG_RST = 11'h000;
endpackage
`default_nettype wire

// ==== hw/dvs_if.sv ====
`default_nettype none
interface dvs_if;
  import dvs_pkg::*;
  logic                wr;
  logic                rd;
  logic [3:0]          addr;
  logic [15:0]         wdata;
  logic [15:0]         rdata;
  logic                enable_pin;
  logic                fault_flag;
  modport device (input wr, rd, addr, wdata, enable_pin,
                  output rdata, fault_flag);
  modport host   (output wr, rd, addr, wdata, enable_pin,
                  input rdata, fault_flag);
endinterface
`default_nettype wire

// ==== hw/dvs_device.sv ====
`default_nettype none
module dvs_device
  import dvs_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic rst_b,
  dvs_if.device     bus,
  output logic      sense_force_full,
  output logic      sense_force_zero,
  output logic      test_res_src,
  output logic      test_res_snk,
  output logic      test_phase_b,
  output logic      gate_enabled
);
  // ************************************************************
  // registers
  // ************************************************************
  logic [CMD_W-1:0]  cmd_ff;
  logic [GATE_W-1:0] gate_ff;
  logic [CFG_W-1:0]  cfg_ff;
  logic [DIAG_W-1:0] diag_ff;
  logic [15:0]       rdata_ff;
  logic [TMR_W-1:0]  ol_tmr_ff;
  logic [TMR_W-1:0]  wd_tmr_ff;
  logic              wd_run_ff;
  logic              en_s1_ff;
  logic              en_s2_ff;
  logic              en_s3_ff;
  logic              gate_en_ff;
  logic              ol_verify_ff;

  // ************************************************************
  // decode
  // ************************************************************
  wire w_cmd   = bus.wr && (bus.addr == ADR_CMD);
  wire w_gate  = bus.wr && (bus.addr == ADR_GATE);
  wire w_cfg   = bus.wr && (bus.addr == ADR_CFG);
  wire w_clr   = bus.wr && (bus.addr == ADR_CLEAR);
  wire [CMD_W-1:0] cmd_wr = bus.wdata[CMD_W-1:0];
  wire gate_ha = gate_ff[0];
  wire gate_hb = gate_ff[1];
  wire low_gate_a = gate_ff[2];
  wire low_gate_b = gate_ff[3];
  wire any_gate   = |gate_ff;
  wire en_edge    = en_s2_ff ^ en_s3_ff;

  // open-load sequences: rising edge of a command restarts the timer
  wire [CMD_W-1:0] nxt_cmd_raw = w_cmd ? cmd_wr : cmd_ff;
  wire ol_any_now = cmd_ff[CMD_OL] | cmd_ff[CMD_SRC] | cmd_ff[CMD_SNK];
  wire ol_start = (nxt_cmd_raw[CMD_OL] & ~cmd_ff[CMD_OL])
                | (nxt_cmd_raw[CMD_SRC] & ~cmd_ff[CMD_SRC])
                | (nxt_cmd_raw[CMD_SNK] & ~cmd_ff[CMD_SNK]);
  wire onst_ok  = cmd_ff[CMD_OL] & cfg_ff[CFG_AOL]
                & (low_gate_a | low_gate_b);
  wire off_ok   = (cmd_ff[CMD_SRC] | cmd_ff[CMD_SNK])
                & ~cfg_ff[CFG_DOO] & ~any_gate;
  wire ol_done  = ol_verify_ff && (ol_tmr_ff == TMR_W'(OL_CYCLES - 1))
                && (onst_ok || off_ok);
  wire wd_done  = wd_run_ff && (wd_tmr_ff == TMR_W'(ETO_CYCLES - 1));

  // latch conditions
  wire set_bua = cmd_ff[CMD_BU] & gate_ha;
  wire set_bub = cmd_ff[CMD_BU] & gate_hb;
  wire set_ha  = cmd_ff[CMD_DO] & low_gate_a;
  wire set_hb  = cmd_ff[CMD_DO] & low_gate_b;
  wire set_la  = cmd_ff[CMD_DO] & gate_ha;
  wire set_lb  = cmd_ff[CMD_DO] & gate_hb;

  wire [DIAG_W-1:0] set_vec;
  assign set_vec[DG_BUA] = set_bua;
  assign set_vec[DG_BUB] = set_bub;
  assign set_vec[DG_HA]  = set_ha;
  assign set_vec[DG_HB]  = set_hb;
  assign set_vec[DG_LA]  = set_la;
  assign set_vec[DG_LB]  = set_lb;
  assign set_vec[DG_LOV] = cmd_ff[CMD_LO];
  assign set_vec[DG_OCA] = cmd_ff[CMD_OC];
  assign set_vec[DG_OCB] = cmd_ff[CMD_OC];
  assign set_vec[DG_OL]  = ol_done;
  assign set_vec[DG_ETO] = wd_done;

  // open-load bit cleared when any open-load command first rises
  wire [DIAG_W-1:0] clr_vec = (w_clr ? bus.wdata[DIAG_W-1:0] : '0)
                    | (ol_start ? (DIAG_W'(1) << DG_OL) : '0);
  // set wins over clear; bits held until cleared
  wire [DIAG_W-1:0] nxt_diag = (diag_ff & ~clr_vec) | set_vec;

  // self clear overrides a same-cycle host write to the bit
  wire self_clr = ol_done & (cmd_ff[CMD_SRC] | cmd_ff[CMD_SNK]);
  wire [CMD_W-1:0] self_mask =
    self_clr ? ((CMD_W'(1) << CMD_SRC) | (CMD_W'(1) << CMD_SNK)) : '0;
  wire [CMD_W-1:0] nxt_cmd = nxt_cmd_raw & ~self_mask;

  // ************************************************************
  // state
  // ************************************************************
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cmd_ff  <= CMD_RST;
      gate_ff <= '0;
      cfg_ff  <= '0;
      diag_ff <= DIAG_RST;
    end else begin
      cmd_ff  <= nxt_cmd;
      gate_ff <= w_gate ? bus.wdata[GATE_W-1:0] : gate_ff;
      cfg_ff  <= w_cfg ? bus.wdata[CFG_W-1:0] : cfg_ff;
      diag_ff <= nxt_diag;
    end
  end

  // open-load timer; dropping the command early abandons it
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ol_tmr_ff    <= '0;
      ol_verify_ff <= 1'b0;
    end else if (ol_start) begin
      ol_tmr_ff    <= '0;
      ol_verify_ff <= 1'b1;
    end else if (!ol_any_now || ol_done) begin
      ol_tmr_ff    <= '0;
      ol_verify_ff <= 1'b0;
    end else begin
      ol_tmr_ff    <= ol_tmr_ff + TMR_W'(1);
    end
  end

  // enable pin arrives from outside: two flops before use
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      en_s1_ff <= 1'b0;
      en_s2_ff <= 1'b0;
      en_s3_ff <= 1'b0;
    end else begin
      en_s1_ff <= bus.enable_pin;
      en_s2_ff <= en_s1_ff;
      en_s3_ff <= en_s2_ff;
    end
  end

  // watchdog: an enable change restarts it, held level lets it expire
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wd_tmr_ff  <= '0;
      wd_run_ff  <= 1'b0;
      gate_en_ff <= 1'b0;
    end else if (cfg_ff[CFG_EWD] && en_edge) begin
      wd_tmr_ff  <= '0;
      wd_run_ff  <= 1'b1;
      gate_en_ff <= 1'b1;
    end else if (!cfg_ff[CFG_EWD] || wd_done) begin
      wd_tmr_ff  <= '0;
      wd_run_ff  <= 1'b0;
      gate_en_ff <= cfg_ff[CFG_EWD] ? 1'b0 : en_s2_ff;
    end else if (wd_run_ff) begin
      wd_tmr_ff  <= wd_tmr_ff + TMR_W'(1);
    end
  end

  // ************************************************************
  // readback
  // ************************************************************
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_ff <= 16'h0000;
    end else if (bus.rd) begin
      unique case (bus.addr)
        ADR_CMD:    rdata_ff <= 16'(cmd_ff);
        ADR_GATE:   rdata_ff <= 16'(gate_ff);
        ADR_CFG:    rdata_ff <= 16'(cfg_ff);
        ADR_DIAG:   rdata_ff <= 16'(diag_ff);
        ADR_STATUS: rdata_ff <= 16'({ol_verify_ff, wd_run_ff});
        default:    rdata_ff <= 16'h0000;
      endcase
    end
  end
  assign bus.rdata = rdata_ff;

  // general flag while a bootstrap verify has a high gate on or a vds verify has any gate on, or whenever LO or OC is commanded
  assign bus.fault_flag = any_gate & (set_bua | set_bub | set_ha
                        | set_hb | set_la | set_lb)
                        | cmd_ff[CMD_LO] | cmd_ff[CMD_OC];
  assign sense_force_full = cmd_ff[CMD_OC];
  assign sense_force_zero = cmd_ff[CMD_OL];
  assign test_res_src = cmd_ff[CMD_SRC];
  assign test_res_snk = cmd_ff[CMD_SNK];
  assign test_phase_b = cmd_ff[CMD_PH];
  assign gate_enabled = gate_en_ff;
endmodule
`default_nettype wire

// ==== hw/dvs_host.sv ====
`default_nettype none
module dvs_host
  import dvs_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  dvs_if.host              bus,
  input  wire logic        usr_wr,
  input  wire logic        usr_rd,
  input  wire logic [3:0]  usr_addr,
  input  wire logic [15:0] usr_wdata,
  input  wire logic        usr_toggle_enable,
  output logic [15:0]      usr_rdata,
  output logic             usr_rvalid,
  output logic             usr_fault
);
  // ************************************************************
  // forwarding; the host keeps enable steady unless asked
  // ************************************************************
  logic        wr_ff;
  logic        rd_ff;
  logic [3:0]  addr_ff;
  logic [15:0] wdata_ff;
  logic        en_ff;
  logic        rpend_ff;
  logic [15:0] rdata_ff;
  logic        rvalid_ff;
  logic        fault_s1_ff;
  logic        fault_s2_ff;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ff     <= 1'b0;
      rd_ff     <= 1'b0;
      addr_ff   <= 4'h0;
      wdata_ff  <= 16'h0000;
      en_ff     <= 1'b0;
      rpend_ff  <= 1'b0;
      rdata_ff  <= 16'h0000;
      rvalid_ff <= 1'b0;
      fault_s1_ff <= 1'b0;
      fault_s2_ff <= 1'b0;
    end else begin
      wr_ff     <= usr_wr;
      rd_ff     <= usr_rd & ~usr_wr;
      addr_ff   <= usr_addr;
      wdata_ff  <= usr_wdata;
      en_ff     <= en_ff ^ usr_toggle_enable;
      rpend_ff  <= rd_ff;
      rvalid_ff <= rpend_ff;
      rdata_ff  <= rpend_ff ? bus.rdata : rdata_ff;
      fault_s1_ff <= bus.fault_flag;
      fault_s2_ff <= fault_s1_ff;
    end
  end
  // user sequences through register writes
  assign bus.wr         = wr_ff;
  assign bus.rd         = rd_ff;
  assign bus.addr       = addr_ff;
  assign bus.wdata      = wdata_ff;
  assign bus.enable_pin = en_ff;
  assign usr_rdata      = rdata_ff;
  assign usr_rvalid     = rvalid_ff;
  assign usr_fault      = fault_s2_ff;
endmodule
`default_nettype wire

// ==== testbench/dvs_props.sv ====
`default_nettype none
module dvs_props
  import dvs_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst_b,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [3:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic [15:0] rdata,
  input wire logic        enable_pin,
  input wire logic        fault_flag
);
  // ****************************************
  // shadow of host writes
  // ****************************************
  // self-clear of source/sink is not seen, so those bits stay out
  logic [7:0] cmd_ff;
  logic [3:0] gate_ff;
  logic       ewd_ff;
  wire        hi_on = |gate_ff[1:0];
  wire        quiet = (cmd_ff[6:2] == 5'h00) && !ewd_ff &&
                      (cmd_ff[1:0] == 2'h0 || gate_ff == 4'h0);
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cmd_ff <= 8'h00;
      gate_ff <= 4'h0;
      ewd_ff <= 1'b0;
    end else if (wr) begin
      if (addr == ADR_CMD) cmd_ff <= wdata[7:0];
      if (addr == ADR_GATE) gate_ff <= wdata[3:0];
      if (addr == ADR_CFG) ewd_ff <= wdata[CFG_EWD];
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  a_no_both: assert property (!(wr && rd))
    else $error("write and read strobes together");
  a_bu_flag: assert property (
    cmd_ff[CMD_BU] && hi_on |-> ##[0:2] fault_flag)
    else $error("bootstrap verify gave no fault flag");
  a_do_flag: assert property (
    cmd_ff[CMD_DO] && gate_ff != 4'h0 |-> ##[0:2] fault_flag)
    else $error("vds verify gave no fault flag");
  a_lo_flag: assert property (
    cmd_ff[CMD_LO] |-> ##[0:2] fault_flag)
    else $error("logic ov verify gave no fault flag");
  a_flag_drop: assert property (
    quiet [*3] |-> !fault_flag)
    else $error("fault flag stays with no verify active");
  a_rd_hold: assert property (!rd |=> $stable(rdata))
    else $error("read data moved without a read");
  a_rd_unmap: assert property ((rd && addr > ADR_STATUS) |=>
    rdata == 16'h0000) else $error("unmapped read not zero");
  a_rd_cmd: assert property (
    rd && addr == ADR_CMD |=> {rdata[7], rdata[4:0]} ==
    $past({cmd_ff[7], cmd_ff[4:0]}))
    else $error("command readback wrong");
endmodule
`default_nettype wire

// ==== testbench/tb_top.sv ====
`default_nettype none
module tb_top
  import dvs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk, rst_b, usr_wr, usr_rd, usr_tog;
  logic [3:0]  usr_addr;
  logic [15:0] usr_wdata, usr_rdata, md, c;
  logic        usr_rvalid, usr_fault;
  logic        sff, sfz, trs, trk, tpb, gen;
  logic [31:0] seed;
  int          miscompares, n_tests, k;
  dvs_if bus ();
  dvs_device u_dvs_device (.ref_clk(ref_clk), .rst_b(rst_b), .bus(bus),
    .sense_force_full(sff), .sense_force_zero(sfz), .test_res_src(trs),
    .test_res_snk(trk), .test_phase_b(tpb), .gate_enabled(gen));
  dvs_host u_dvs_host (.ref_clk(ref_clk), .rst_b(rst_b), .bus(bus),
    .usr_wr(usr_wr), .usr_rd(usr_rd), .usr_addr(usr_addr),
    .usr_wdata(usr_wdata), .usr_toggle_enable(usr_tog),
    .usr_rdata(usr_rdata), .usr_rvalid(usr_rvalid), .usr_fault(usr_fault));
  dvs_props u_dvs_props (.ref_clk(ref_clk), .rst_b(rst_b), .wr(bus.wr),
    .rd(bus.rd), .addr(bus.addr), .wdata(bus.wdata), .rdata(bus.rdata),
    .enable_pin(bus.enable_pin), .fault_flag(bus.fault_flag));
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic print_verdict();
    if (miscompares == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // host flag passes two flops, so settle before looking
  task automatic flg(input logic e);
    tick(5);
    @(negedge ref_clk);
    chk({15'h0000, usr_fault}, {15'h0000, e});
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    usr_wr <= 1'b1;
    usr_addr <= a;
    usr_wdata <= d;
    @(posedge ref_clk);
    usr_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    int i;
    @(posedge ref_clk);
    usr_rd <= 1'b1;
    usr_addr <= a;
    @(posedge ref_clk);
    usr_rd <= 1'b0;
    for (i = 0; i < 10; i++) begin
      @(negedge ref_clk);
      if (usr_rvalid === 1'b1) break;
    end
    if (i == 10) begin
      miscompares++;
      print_verdict();
    end else begin
      chk(usr_rdata, e);
    end
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {rst_b, usr_wr, usr_rd, usr_tog, usr_addr, usr_wdata} = '0;
    {miscompares, n_tests} = '0;
    md = 16'h0000;
    seed = 32'hfdf3006a;
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'b1;
    rd(4'hf, 16'h0000);
    wr(ADR_CMD, 16'h0001);
    for (k = 0; k < 2; k++) begin
      wr(ADR_GATE, 16'h0001 << k);
      md |= 16'h0001 << (DG_BUA + k);
      flg(1'b1);
      rd(ADR_DIAG, md);
    end
    wr(ADR_GATE, 16'h0000);
    flg(1'b0);
    wr(ADR_CMD, 16'h0002);
    // low gate trips the high-side bit and the other way round
    for (k = 0; k < 4; k++) begin
      wr(ADR_GATE, 16'h0001 << k);
      md |= 16'h0001 << ((k < 2) ? DG_LA + k : DG_HA + k - 2);
      flg(1'b1);
    end
    wr(ADR_CMD, 16'h0000);
    flg(1'b0);
    wr(ADR_GATE, 16'h0000);
    rd(ADR_DIAG, md);
    wr(ADR_CMD, 16'h0004);
    md |= 16'h0001 << DG_LOV;
    flg(1'b1);
    // threshold plus offset assumed in range; analog side not modelled
    wr(ADR_CMD, 16'h0008);
    md |= 16'h0003 << DG_OCA;
    tick(4);
    @(negedge ref_clk);
    chk({15'h0000, sff}, 16'h0001);
    wr(ADR_CMD, 16'h0000);
    flg(1'b0);
    chk({15'h0000, sff}, 16'h0000);
    rd(ADR_DIAG, md);
    wr(ADR_DIAG, 16'h0000);
    seed = xs(seed);
    wr(ADR_CLEAR, seed[15:0]);
    md &= ~{5'h00, seed[10:0]};
    rd(ADR_DIAG, md);
    wr(ADR_CLEAR, 16'h07ff);
    md = 16'h0000;
    wr(ADR_CFG, 16'h0001);
    wr(ADR_GATE, 16'h0004);
    wr(ADR_CMD, 16'h0010);
    tick(100);
    @(negedge ref_clk);
    chk({15'h0000, sfz}, 16'h0001);
    wr(ADR_CMD, 16'h0000);
    rd(ADR_DIAG, md);
    wr(ADR_CMD, 16'h0010);
    tick(OL_CYCLES + 20);
    md |= 16'h0001 << DG_OL;
    wr(ADR_CMD, 16'h0000);
    wr(ADR_CFG, 16'h0000);
    wr(ADR_GATE, 16'h0000);
    rd(ADR_DIAG, md);
    // source then sink, each on phase a and b
    for (k = 0; k < 4; k++) begin
      c = (16'h0020 << (k / 2)) | ((k % 2) ? 16'h0080 : 16'h0000);
      wr(ADR_CMD, c);
      tick(3);
      @(negedge ref_clk);
      chk({13'h0000, trs, trk, tpb},
          ((k < 2) ? 16'h0004 : 16'h0002) | 16'(k % 2));
      tick(OL_CYCLES + 20);
      @(negedge ref_clk);
      chk({14'h0000, trs, trk}, 16'h0000);
      rd(ADR_CMD, c & 16'h0080);
      rd(ADR_DIAG, md);
    end
    wr(ADR_CLEAR, 16'h07ff);
    md = 16'h0000;
    for (k = 0; k < 2; k++) begin
      wr(ADR_CMD, 16'h0020 << k);
      tick(100);
      wr(ADR_CMD, 16'h0000);
      rd(ADR_DIAG, md);
    end
    wr(ADR_CFG, 16'h0004);
    @(posedge ref_clk);
    usr_tog <= 1'b1;
    @(posedge ref_clk);
    usr_tog <= 1'b0;
    tick(10);
    @(negedge ref_clk);
    chk({15'h0000, gen}, 16'h0001);
    tick(ETO_CYCLES + 20);
    md |= 16'h0001 << DG_ETO;
    rd(ADR_DIAG, md);
    print_verdict();
  end
endmodule
`default_nettype wire
